// ---- logic/blink_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module blink_timer
   import lcd_cmd_pkg::*;
#(
   parameter int HALF_CYC = BLINK_HALF_CYC_DEF
)
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [1:0] rate_i,
   output logic            visible_o
);
   logic [BLINK_CNT_W-1:0] cnt_reg;
   logic [BLINK_CNT_W-1:0] cnt_next;
   logic [BLINK_CNT_W-1:0] limit;
   logic [1:0]             rate_reg;
   logic [1:0]             rate_next;
   logic                   phase_reg;
   logic                   phase_next;

   always_comb
   begin
      case (rate_i)
         BLINK_2HZ:     limit = BLINK_CNT_W'(HALF_CYC - 1);
         BLINK_1HZ:     limit = BLINK_CNT_W'(2 * HALF_CYC - 1);
         BLINK_HALF_HZ: limit = BLINK_CNT_W'(4 * HALF_CYC - 1);
         default:       limit = '0;
      endcase
      rate_next  = rate_i;
      cnt_next   = cnt_reg + BLINK_CNT_W'(1);
      phase_next = phase_reg;
      // restart on a new rate so the first lit half is full length
      if (rate_i != rate_reg || rate_i == BLINK_OFF)
      begin
         cnt_next   = '0;
         phase_next = 1'h1;
      end
      else if (cnt_reg >= limit)
      begin
         cnt_next   = '0;
         phase_next = ~phase_reg;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_reg   <= '0;
         rate_reg  <= BLINK_OFF;
         phase_reg <= 1'h1;
      end
      else
      begin
         cnt_reg   <= cnt_next;
         rate_reg  <= rate_next;
         phase_reg <= phase_next;
      end
   end

   assign visible_o = phase_reg;
endmodule : blink_timer
`default_nettype wire

// ---- logic/lcd_blink_bias_cmd.sv ----
// What this block does
// R1 - a byte 110000xx sets the blink rate (off, 2Hz, 1Hz, 0.5Hz), reset 0xc0.
// R2 - a byte 01xxxxxx is stored as the drive-voltage setting, bit 4 enabling adjustment, reset 0x70.
// R3 - the low four bits pick one of sixteen drive-voltage levels.
// R4 - bit 5 makes the shared pin a segment output when 1, a drive-voltage pin when 0.
// R5 - level 0000 turns the voltage follower off, any other level turns it on.
// R6 - drive-voltage role with adjustment off takes the drive voltage from outside.
// R7 - the host picks a nonzero level when a resistor to the supply sets the bias.
// R8 - the host picks level 0000 when the pin is tied straight to the supply.
// R9 - with adjustment on the drive voltage is made inside in either pin role.
// R10 - drive-voltage role with adjustment on drives the pin as a monitorable output.
// R11 - segment role with adjustment off biases from the supply and ignores the level.
// R12 - after power-on adjustment is off and the shared pin is a segment output.
// R13 - a command byte of no known encoding changes nothing.
// R14 - a write is start, address+write, command, data, stop, each byte acknowledged.
// R15 - the byte after a command byte is acknowledged and ignored.
// R16 - a setting changes once its whole command byte is accepted; blink timing is internal.
`timescale 1ns/1ns
`default_nettype none
module lcd_blink_bias_cmd
   import lcd_cmd_pkg::*;
#(
   parameter int BLINK_HALF_CYC = BLINK_HALF_CYC_DEF
)
(
   input  wire logic       CLK_I,
   input  wire logic       RST_I,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE_O,
   output logic [1:0]      BLINK_RATE_O,
   output logic            BLINK_VISIBLE_O,
   output var drive_cfg_t  DRIVE_CFG_O,
   output logic            FOLLOWER_EN_O,
   output logic            LCD_DRIVE_VOLTAGE_INTERNAL_O,
   output logic            LCD_DRIVE_VOLTAGE_PIN_DRIVE_O,
   output logic            LCD_DRIVE_VOLTAGE_EXT_IN_O,
   output logic            BIAS_FROM_VDD_O
);

   typedef enum {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_CMD,
      ST_ACK_CMD,
      ST_DATA,
      ST_ACK_DATA
   } bus_state_t;

   bus_pins_t  pins_s;
   logic       scl_prev_reg;
   logic       scl_prev_next;
   logic       sda_prev_reg;
   logic       sda_prev_next;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_cond;
   logic       stop_cond;

   bus_state_t state_reg;
   bus_state_t state_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [3:0] bit_cnt_reg;
   logic [3:0] bit_cnt_next;
   logic       byte_done;
   logic       cmd_done;

   logic [7:0] blink_rate_setting_reg;
   logic [7:0] blink_rate_setting_next;
   logic [7:0] drive_voltage_setting_reg;
   logic [7:0] drive_voltage_setting_next;
   logic       vadj_seen_reg;
   logic       vadj_seen_next;

   drive_cfg_t cfg_reg;
   drive_cfg_t cfg_next;
   logic [4:0] flags_reg;
   logic [4:0] flags_next;

   pin_sync u_pin_sync (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .pins_i ('{scl: SCL_I, sda: SDA_I}),
      .pins_o (pins_s)
   );

   // edge detection only on the synchronised copies
   assign scl_rise   = pins_s.scl & ~scl_prev_reg;
   assign scl_fall   = ~pins_s.scl & scl_prev_reg;
   assign start_cond = pins_s.scl & scl_prev_reg & sda_prev_reg & ~pins_s.sda;
   assign stop_cond  = pins_s.scl & scl_prev_reg & ~sda_prev_reg & pins_s.sda;
   assign byte_done  = scl_fall && bit_cnt_reg == 4'h8;
   assign cmd_done   = state_reg == ST_CMD && byte_done
                       && !start_cond && !stop_cond;

   // serial write receiver
   always_comb
   begin
      scl_prev_next = pins_s.scl;
      sda_prev_next = pins_s.sda;
      state_next    = state_reg;
      shift_next    = shift_reg;
      bit_cnt_next  = bit_cnt_reg;
      if (start_cond)
      begin
         state_next   = ST_ADDR; // [R14]
         bit_cnt_next = 4'h0;
      end
      else if (stop_cond)
         state_next = ST_IDLE;
      else
      begin
         case (state_reg)
            ST_ADDR, ST_CMD, ST_DATA:
               if (scl_rise)
               begin
                  shift_next   = {shift_reg[6:0], pins_s.sda};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end
               else if (byte_done)
               begin
                  // read requests are not ours to answer
                  if (state_reg == ST_ADDR)
                     state_next = (shift_reg == {SLAVE_ADDR, DIR_WRITE})
                                  ? ST_ACK_ADDR : ST_IDLE; // [R14]
                  else if (state_reg == ST_CMD)
                     state_next = ST_ACK_CMD; // [R14]
                  else
                     state_next = ST_ACK_DATA; // [R15]
               end
            ST_ACK_ADDR, ST_ACK_CMD, ST_ACK_DATA:
               if (scl_fall)
               begin
                  bit_cnt_next = 4'h0;
                  state_next   = (state_reg == ST_ACK_ADDR) ? ST_CMD
                                 : ST_DATA; // [R15]
               end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         state_reg   <= ST_IDLE;
         shift_reg   <= 8'h00;
         bit_cnt_reg <= 4'h0;
         // idle bus level, so no false edge after reset
         scl_prev_reg <= 1'h1;
         sda_prev_reg <= 1'h1;
      end
      else
      begin
         state_reg   <= state_next;
         shift_reg   <= shift_next;
         bit_cnt_reg <= bit_cnt_next;
         scl_prev_reg <= scl_prev_next;
         sda_prev_reg <= sda_prev_next;
      end
   end

   // open drain: only ever pull low, during the ack slot
   assign SDA_O    = 1'h0;
   assign SDA_OE_O = state_reg == ST_ACK_ADDR || state_reg == ST_ACK_CMD
                     || state_reg == ST_ACK_DATA; // [R14]

   // command decode on the fall that closes the command byte
   always_comb
   begin
      blink_rate_setting_next    = blink_rate_setting_reg;
      drive_voltage_setting_next = drive_voltage_setting_reg;
      vadj_seen_next             = vadj_seen_reg;
      if (cmd_done)
      begin
         if (is_blink_cmd(shift_reg))
            blink_rate_setting_next = shift_reg; // [R1] [R16]
         else if (is_vadj_cmd(shift_reg))
         begin
            drive_voltage_setting_next = shift_reg; // [R2] [R16]
            vadj_seen_next             = 1'h1;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         blink_rate_setting_reg    <= BLINK_RESET; // [R1]
         drive_voltage_setting_reg <= VADJ_RESET; // [R2]
         vadj_seen_reg             <= 1'h0;
      end
      else
      begin
         blink_rate_setting_reg    <= blink_rate_setting_next;
         drive_voltage_setting_reg <= drive_voltage_setting_next;
         vadj_seen_reg             <= vadj_seen_next;
      end
   end

   // the reset byte has the enable bit set, yet power-on must stay
   // unadjusted, so enable is held off until a real command lands
   always_comb
   begin
      cfg_next.shared_pin_role_sel =
         vadj_seen_reg ? drive_voltage_setting_reg[ROLE_BIT] : 1'h1; // [R4] [R12]
      cfg_next.voltage_adjust_enable =
         vadj_seen_reg & drive_voltage_setting_reg[ADJ_EN_BIT]; // [R12]
      cfg_next.drive_level_field =
         drive_voltage_setting_reg[LEVEL_MSB:0]; // [R3]
      // order: follower, internal, pin drive, external in, supply bias
      flags_next[4] =
         cfg_next.drive_level_field != LEVEL_FOLLOWER_OFF; // [R5]
      flags_next[3] = cfg_next.voltage_adjust_enable; // [R9]
      flags_next[2] = cfg_next.voltage_adjust_enable
                      & ~cfg_next.shared_pin_role_sel; // [R10]
      flags_next[1] = ~cfg_next.voltage_adjust_enable
                      & ~cfg_next.shared_pin_role_sel; // [R6]
      flags_next[0] = ~cfg_next.voltage_adjust_enable
                      & cfg_next.shared_pin_role_sel; // [R11]
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         cfg_reg   <= '{shared_pin_role_sel: 1'h1,
                        voltage_adjust_enable: 1'h0,
                        drive_level_field: 4'h0};
         flags_reg <= 5'h01;
      end
      else
      begin
         cfg_reg   <= cfg_next;
         flags_reg <= flags_next;
      end
   end

   assign DRIVE_CFG_O      = cfg_reg;
   assign FOLLOWER_EN_O    = flags_reg[4];
   assign LCD_DRIVE_VOLTAGE_INTERNAL_O  = flags_reg[3];
   assign LCD_DRIVE_VOLTAGE_PIN_DRIVE_O = flags_reg[2];
   assign LCD_DRIVE_VOLTAGE_EXT_IN_O    = flags_reg[1];
   assign BIAS_FROM_VDD_O  = flags_reg[0];
   assign BLINK_RATE_O     = blink_rate_setting_reg[1:0];

   blink_timer #(
      .HALF_CYC (BLINK_HALF_CYC)
   ) u_blink_timer (
      .clk_i     (CLK_I),
      .rst_i     (RST_I),
      .rate_i    (blink_rate_setting_reg[1:0]), // [R16]
      .visible_o (BLINK_VISIBLE_O)
   );

   property p_blink_store;
      @(posedge CLK_I) disable iff (RST_I)
      cmd_done && is_blink_cmd(shift_reg)
      |=> blink_rate_setting_reg == {BLINK_CMD_PREFIX, $past(shift_reg[1:0])}
          ##2 BLINK_RATE_O == $past(shift_reg[1:0], 3);
   endproperty
   a_blink_store: assert property (p_blink_store) // [R1]
      else $error("blink command not stored");

   property p_vadj_store;
      @(posedge CLK_I) disable iff (RST_I)
      cmd_done && is_vadj_cmd(shift_reg)
      |=> drive_voltage_setting_reg == $past(shift_reg) ##1
          DRIVE_CFG_O.drive_level_field == $past(shift_reg[3:0], 2);
   endproperty
   a_vadj_store: assert property (p_vadj_store) // [R2]
      else $error("voltage command not stored");

   property p_follower;
      @(posedge CLK_I) disable iff (RST_I)
      FOLLOWER_EN_O == (DRIVE_CFG_O.drive_level_field != LEVEL_FOLLOWER_OFF);
   endproperty
   a_follower: assert property (p_follower) // [R5]
      else $error("follower enable does not match level");

   property p_unknown_cmd;
      @(posedge CLK_I) disable iff (RST_I)
      cmd_done && !is_blink_cmd(shift_reg) && !is_vadj_cmd(shift_reg)
      |=> $stable(blink_rate_setting_reg) && $stable(drive_voltage_setting_reg);
   endproperty
   a_unknown_cmd: assert property (p_unknown_cmd) // [R13]
      else $error("undefined command changed a setting");

   property p_ack_slot;
      @(posedge CLK_I) disable iff (RST_I)
      cmd_done |=> SDA_OE_O [*2];
   endproperty
   a_ack_slot: assert property (p_ack_slot) // [R14]
      else $error("command byte not acknowledged");

   property p_data_ignored;
      @(posedge CLK_I) disable iff (RST_I)
      (state_reg == ST_DATA || state_reg == ST_ACK_DATA)
      |=> $stable(blink_rate_setting_reg) && $stable(drive_voltage_setting_reg);
   endproperty
   a_data_ignored: assert property (p_data_ignored) // [R15]
      else $error("data byte after command changed a setting");

   property p_power_on;
      @(posedge CLK_I) disable iff (RST_I)
      !vadj_seen_reg && !$rose(vadj_seen_reg)
      |=> !DRIVE_CFG_O.voltage_adjust_enable
          && DRIVE_CFG_O.shared_pin_role_sel && BIAS_FROM_VDD_O;
   endproperty
   a_power_on: assert property (p_power_on) // [R12]
      else $error("adjustment active before any voltage command");

   property p_pin_drive;
      @(posedge CLK_I) disable iff (RST_I)
      LCD_DRIVE_VOLTAGE_PIN_DRIVE_O |-> LCD_DRIVE_VOLTAGE_INTERNAL_O && !DRIVE_CFG_O.shared_pin_role_sel
                           && !LCD_DRIVE_VOLTAGE_EXT_IN_O;
   endproperty
   a_pin_drive: assert property (p_pin_drive) // [R10]
      else $error("drive pin output without internal voltage");
   property p_ext_in;
      @(posedge CLK_I) disable iff (RST_I)
      LCD_DRIVE_VOLTAGE_EXT_IN_O |-> !LCD_DRIVE_VOLTAGE_INTERNAL_O && !BIAS_FROM_VDD_O;
   endproperty
   a_ext_in: assert property (p_ext_in) // [R6]
      else $error("external drive voltage while generating internally");

   property p_vdd_bias;
      @(posedge CLK_I) disable iff (RST_I)
      BIAS_FROM_VDD_O == (DRIVE_CFG_O.shared_pin_role_sel
                          && !LCD_DRIVE_VOLTAGE_INTERNAL_O);
   endproperty
   a_vdd_bias: assert property (p_vdd_bias) // [R11]
      else $error("supply bias flag wrong for segment role");
endmodule : lcd_blink_bias_cmd
`default_nettype wire

// ---- logic/lcd_cmd_pkg.sv ----
package lcd_cmd_pkg;

   // serial slave address and direction
   localparam logic [6:0]  SLAVE_ADDR        = 7'h3f;
   localparam logic        DIR_WRITE         = 1'h0;

   // command byte encodings
   localparam logic [5:0]  BLINK_CMD_PREFIX  = 6'h30;
   localparam logic [1:0]  VADJ_CMD_PREFIX   = 2'h1;

   // stored setting reset values
   localparam logic [7:0]  BLINK_RESET       = 8'hc0;
   localparam logic [7:0]  VADJ_RESET        = 8'h70;

   // field positions in the voltage-adjust byte
   localparam int          ROLE_BIT          = 5;
   localparam int          ADJ_EN_BIT        = 4;
   localparam int          LEVEL_MSB         = 3;
   localparam logic [3:0]  LEVEL_FOLLOWER_OFF = 4'h0;

   // blink rate select encodings
   localparam logic [1:0]  BLINK_OFF         = 2'h0;
   localparam logic [1:0]  BLINK_2HZ         = 2'h1;
   localparam logic [1:0]  BLINK_1HZ         = 2'h2;
   localparam logic [1:0]  BLINK_HALF_HZ     = 2'h3;

   // timing
   localparam int          CLK_HZ            = 50_000_000;
   localparam int          BLINK_2HZ_HALF_MS = 250;
   localparam int          BLINK_HALF_CYC_DEF =
      (CLK_HZ / 1000) * BLINK_2HZ_HALF_MS;
   localparam int          BLINK_CNT_W       = 26;

   typedef struct packed {
      logic       shared_pin_role_sel;
      logic       voltage_adjust_enable;
      logic [3:0] drive_level_field;
   } drive_cfg_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } bus_pins_t;

   function automatic logic is_blink_cmd(input logic [7:0] b);
      return b[7:2] == BLINK_CMD_PREFIX;
   endfunction : is_blink_cmd

   function automatic logic is_vadj_cmd(input logic [7:0] b);
      return b[7:6] == VADJ_CMD_PREFIX;
   endfunction : is_vadj_cmd

endpackage : lcd_cmd_pkg

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module pin_sync
   import lcd_cmd_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   input  wire bus_pins_t pins_i,
   output var bus_pins_t  pins_o
);
   // idle bus is high, so reset to high to avoid a false start
   bus_pins_t stage1_reg;
   bus_pins_t stage1_next;
   bus_pins_t stage2_reg;
   bus_pins_t stage2_next;

   always_comb
   begin
      stage1_next = pins_i;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         stage1_reg <= '{scl: 1'h1, sda: 1'h1};
         stage2_reg <= '{scl: 1'h1, sda: 1'h1};
      end
      else
      begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign pins_o = stage2_reg;
endmodule : pin_sync
`default_nettype wire

// ---- verification/i2c_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);

   // scl is push-pull and idles high; sda released means pull-up
   initial
   begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // 160 ns bit: sda moves mid-low, sampled mid-high
   task automatic put_bit(input logic b, output logic seen);
      tick(2);
      sda_low_o <= !b;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      seen = sda_i;
      tick(2);
      scl_o <= 1'b0;
   endtask : put_bit

   // start, address, command, data, stop; ack seen per byte
   task automatic write_frame(input logic [23:0] f, output logic [2:0] acks);
      logic s;
      tick(1);
      sda_low_o <= 1'b1;
      tick(4);
      scl_o <= 1'b0;
      for (int j = 0; j < 3; j++)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            put_bit(f[8 * (2 - j) + i], s);
         end
         put_bit(1'b1, s);
         acks[2 - j] = !s;
      end
      tick(2);
      sda_low_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b0;
      tick(4);
   endtask : write_frame

endmodule : i2c_host_model
`default_nettype wire

// ---- verification/lcd_blink_bias_cmd_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module lcd_blink_bias_cmd_tb;
   import lcd_cmd_pkg::*;

   // short blink half period keeps the run small
   localparam int HALF = 16;

   logic       clk;
   logic       rst;
   wire logic  scl;
   wire logic  sda_low;
   logic       sda_wire;
   logic       sda_out;
   logic       sda_oe;
   logic [1:0] blink_rate;
   logic       visible;
   drive_cfg_t cfg;
   logic       follower;
   logic       internal;
   logic       pin_drive;
   logic       ext_in;
   logic       bias_vdd;
   int         errors;
   int         comparisons;
   int         cycles;
   int         n;
   // 0x40 pin tied to supply 0x41 resistor bias
   logic [7:0] vtab [8] = '{8'h40, 8'h41, 8'h4f, 8'h50,
                            8'h5f, 8'h60, 8'h7f, 8'h65};

   // open drain: either party may pull low
   assign sda_wire = !(sda_low | (sda_oe & !sda_out));

   i2c_host_model host
   (
      .clk_i     (clk),
      .sda_i     (sda_wire),
      .scl_o     (scl),
      .sda_low_o (sda_low)
   );

   lcd_blink_bias_cmd #(.BLINK_HALF_CYC(HALF)) dut
   (
      .CLK_I            (clk),
      .RST_I            (rst),
      .SCL_I            (scl),
      .SDA_I            (sda_wire),
      .SDA_O            (sda_out),
      .SDA_OE_O         (sda_oe),
      .BLINK_RATE_O     (blink_rate),
      .BLINK_VISIBLE_O  (visible),
      .DRIVE_CFG_O      (cfg),
      .FOLLOWER_EN_O    (follower),
      .LCD_DRIVE_VOLTAGE_INTERNAL_O  (internal),
      .LCD_DRIVE_VOLTAGE_PIN_DRIVE_O (pin_drive),
      .LCD_DRIVE_VOLTAGE_EXT_IN_O    (ext_in),
      .BIAS_FROM_VDD_O  (bias_vdd)
   );

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      errors = 0;
      comparisons = 0;
      cycles = 0;
   end

   always #10 clk = !clk;

   task automatic end_of_test();
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // a hang costs a mismatch
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_of_test();
      end
   end

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      comparisons++;
      if (got !== exp)
      begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : check

   // v = {role, enable, level}
   task automatic check_outs(input logic [5:0] v, input logic [1:0] r);
      check("drive_cfg", {2'h0, v}, {2'h0, cfg});
      check("follower", {7'h0, |v[3:0]}, {7'h0, follower});
      check("internal", {7'h0, v[4]}, {7'h0, internal});
      check("pin_drive", {7'h0, v[4] & !v[5]}, {7'h0, pin_drive});
      check("ext_in", {7'h0, !v[4] & !v[5]}, {7'h0, ext_in});
      check("bias_vdd", {7'h0, v[5] & !v[4]}, {7'h0, bias_vdd});
      check("blink_rate", {6'h0, r}, {6'h0, blink_rate});
   endtask : check_outs

   task automatic send(input logic [23:0] f, input logic [2:0] exp_acks);
      logic [2:0] a;
      host.write_frame(f, a);
      check("acks", {5'h0, exp_acks}, {5'h0, a});
   endtask : send

   // length of one dark phase, 0 when blink never darkens
   task automatic blink_low_run(output int len);
      int w;
      len = 0;
      w = 0;
      // sampled on the falling edge, clear of the register update
      while (visible !== 1'b1 && w < 300)
      begin
         @(negedge clk);
         w++;
      end
      while (visible !== 1'b0 && w < 300)
      begin
         @(negedge clk);
         w++;
      end
      while (visible === 1'b0 && len < 300)
      begin
         @(negedge clk);
         len++;
      end
   endtask : blink_low_run

   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check_outs(6'h20, 2'h0);
      send({8'h7c, 8'h41, 8'h3c}, 3'h0);
      send({8'h7f, 8'h41, 8'h3c}, 3'h0);
      check_outs(6'h20, 2'h0);
      foreach (vtab[k])
      begin
         send({8'h7e, vtab[k], 8'h3c}, 3'h7);
         check_outs(vtab[k][5:0], 2'h0);
      end
      send({8'h7e, 8'h1f, 8'h41}, 3'h7);
      send({8'h7e, 8'h00, 8'h50}, 3'h7);
      check_outs(6'h25, 2'h0);
      // data byte would be a voltage command if it were not dropped
      for (int i = 3; i >= 0; i--)
      begin
         send({8'h7e, 6'h30, 2'(i), 8'h7f}, 3'h7);
         check_outs(6'h25, 2'(i));
         blink_low_run(n);
         check("dark", (i == 0) ? 8'h0 : 8'(HALF << (i - 1)), 8'(n));
      end
      // second reset mid run brings the power-on state back
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check_outs(6'h20, 2'h0);
      check("visible", 8'h1, {7'h0, visible});
      end_of_test();
   end

endmodule : lcd_blink_bias_cmd_tb
`default_nettype wire
